// ### sdram_cmd_consts.vh
// Constants for the command decoder and mode-register logic of the low-power DDR SDRAM model.
// Assumes it is included by bare name from each design file that needs it.
`ifndef SDRAM_CMD_CONSTS_VH
`define SDRAM_CMD_CONSTS_VH

// Command codes as {chip select, row strobe, column strobe, write enable}, all active low.
`define CMD_LOAD_MODE      4'h0
`define CMD_REFRESH        4'h1
`define CMD_PRECHARGE      4'h2
`define CMD_ACTIVE         4'h3
`define CMD_WRITE          4'h4
`define CMD_READ           4'h5
`define CMD_BURST_STOP     4'h6
`define CMD_NOP            4'h7

// Bank address codes {BA1, BA0} that steer a load-mode-register command.
`define BA_SEL_MODE        2'h0
`define BA_SEL_STATUS      2'h1
`define BA_SEL_EXT         2'h2

// Standard mode register fields.
`define MR_BL_LSB          0
`define MR_BT_BIT          3
`define MR_CL_LSB          4
`define MR_RESET           7'h32

// Extended mode register fields.
`define EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB       0
`define EMR_TEMP_LSB       3
`define EMR_DS_LSB         5
`define EMR_KEEP_MASK      7'h67
`define EMR_RESET          7'h00

// Partial-array refresh select codes.
`define PARTIAL_ARRAY_REFRESH_SELECT_FULL          3'h0
`define PARTIAL_ARRAY_REFRESH_SELECT_HALF          3'h1
`define PARTIAL_ARRAY_REFRESH_SELECT_QUARTER       3'h2
`define PARTIAL_ARRAY_REFRESH_SELECT_EIGHTH        3'h5
`define PARTIAL_ARRAY_REFRESH_SELECT_SIXTEENTH     3'h6

// Auto-precharge / precharge-all address bit.
`define AP_BIT             10

// Timing, counted in link clock edges.
`define WRITE_LATENCY_CK   1
`define STATUS_BURST_BEATS 5'h02
`define MIN_READ_LATENCY   3'h2

`endif

// ### sdram_word_store.v
// Small word array with per-byte write inhibit and a registered read port.
// Assumes one clock; write and read addresses are presented for one cycle.
`timescale 1ns/1ps
`default_nettype none
module sdram_word_store #(
	parameter DATA_W = 16,
	parameter ADDR_W = 8,
	parameter MASK_W = 2
) (
	input  wire              clk,
	input  wire              wrEn,
	input  wire [ADDR_W-1:0] wrAddr,
	input  wire [DATA_W-1:0] wrData,
	input  wire [MASK_W-1:0] wrMask,
	input  wire [ADDR_W-1:0] rdAddr,
	output reg  [DATA_W-1:0] rdData
);
	reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	genvar lane;
	generate
		for (lane = 0; lane < MASK_W; lane = lane + 1) begin : g_lane
			// A high mask bit leaves the stored byte untouched.
			always @(posedge clk) begin
				if (wrEn && !wrMask[lane]) begin
					mem[wrAddr][lane*8 +: 8] <= wrData[lane*8 +: 8];
				end
			end
		end
	endgenerate

	always @(posedge clk) begin
		rdData <= mem[rdAddr];
	end
endmodule // sdram_word_store
`default_nettype wire

// ### sdram_command_mode_logic.v
// Command decoder, mode registers, status read and burst engines of a low-power DDR SDRAM.
// Assumes the controller drives pins from the link clock; clk samples them all, link clock too.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cmd_consts.vh"

module sdram_command_mode_logic #(
	parameter ADDR_W      = 14,
	parameter DATA_W      = 16,
	parameter MASK_W      = 2,
	parameter COL_W       = 6,
	parameter ROW_W       = 13,
	// Status word contents; the value is arbitrary.
	parameter STATUS_WORD = 16'h0A50
) (
	input  wire              clk,
	input  wire              rstn,
	input  wire              linkClk,
	input  wire              cke,
	input  wire              csN,
	input  wire              rasN,
	input  wire              casN,
	input  wire              weN,
	input  wire [1:0]        ba,
	input  wire [ADDR_W-1:0] addr,
	input  wire [DATA_W-1:0] wrData,
	input  wire [MASK_W-1:0] dm,
	output wire [DATA_W-1:0] rdData,
	output wire              rdValid,
	input  wire              rdReady,
	output reg  [2:0]        casLatency,
	output reg  [2:0]        burstLenCode,
	output reg               burstInterleaved,
	output reg  [2:0]        pasrSelect,
	output reg  [1:0]        driveStrength,
	output reg  [6:0]        driveOhms,
	output reg               selfRefresh,
	output reg               deepPowerDown,
	output reg  [3:0]        refreshBankMask,
	output reg  [1:0]        refreshRowMsbZero,
	output reg  [3:0]        openBanks,
	output reg  [ROW_W-1:0]  refreshRow
);
	localparam SYNC_W = 6 + 2 + ADDR_W + DATA_W + MASK_W;
	localparam MEM_AW = 2 + COL_W;
	localparam [2:0] PS_ACTIVE = 3'b001;
	localparam [2:0] PS_SELF   = 3'b010;
	localparam [2:0] PS_DEEP   = 3'b100;

	function [4:0] burstBeats;
		input [2:0] code;
		begin
			case (code)
				3'h1:    burstBeats = 5'h02;
				3'h2:    burstBeats = 5'h04;
				3'h3:    burstBeats = 5'h08;
				3'h4:    burstBeats = 5'h10;
				default: burstBeats = 5'h04;
			endcase
		end
	endfunction

	// Column of a beat inside the wrapped burst block.
	function [COL_W-1:0] beatCol;
		input [COL_W-1:0] start;
		input [4:0]       idx;
		input [4:0]       len;
		input             inter;
		reg   [COL_W-1:0] m;
		reg   [COL_W-1:0] i;
		begin
			m = {{(COL_W-5){1'b0}}, len - 5'h01};
			i = {{(COL_W-5){1'b0}}, idx};
			if (inter) begin
				beatCol = start ^ (i & m);
			end else begin
				beatCol = (start & ~m) | ((start + i) & m);
			end
		end
	endfunction

	// Three-stage pin synchroniser; a bit changes once stages two and three agree.
	wire [SYNC_W-1:0] pinRaw = {linkClk, cke, csN, rasN, casN, weN, ba, addr, wrData, dm};
	reg  [SYNC_W-1:0] sync1_q;
	reg  [SYNC_W-1:0] sync2_q;
	reg  [SYNC_W-1:0] sync3_q;
	reg  [SYNC_W-1:0] pinF_q;
	wire [SYNC_W-1:0] agree = ~(sync2_q ^ sync3_q);
	wire [SYNC_W-1:0] pinF_d = (sync3_q & agree) | (pinF_q & ~agree);

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= {SYNC_W{1'b0}};
			sync2_q <= {SYNC_W{1'b0}};
			sync3_q <= {SYNC_W{1'b0}};
			pinF_q  <= {SYNC_W{1'b0}};
		end else begin
			sync1_q <= pinRaw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pinF_q  <= pinF_d;
		end
	end

	wire              ckS   = pinF_q[SYNC_W-1];
	wire              ckeS  = pinF_q[SYNC_W-2];
	wire [3:0]        cmdS  = pinF_q[SYNC_W-3 -: 4];
	wire [1:0]        baS   = pinF_q[SYNC_W-7 -: 2];
	wire [ADDR_W-1:0] addrS = pinF_q[DATA_W+MASK_W +: ADDR_W];
	wire [DATA_W-1:0] wdS   = pinF_q[MASK_W +: DATA_W];
	wire [MASK_W-1:0] dmS   = pinF_q[MASK_W-1:0];

	reg  ckPrev_q;
	reg  ckePrev_q;
	wire ckRise = ckS & ~ckPrev_q;
	wire ckEdge = ckS ^ ckPrev_q;
	wire [3:0] cmd = cmdS[3] ? `CMD_NOP : cmdS;
	wire apBit = addrS[`AP_BIT];

	reg  [2:0] pwr_q;
	reg  [6:0] modeReg_q;
	reg  [6:0] extReg_q;
	reg        statusArmed_q;
	wire       cmdLive = ckRise && pwr_q == PS_ACTIVE && ckePrev_q && ckeS;
	wire       lowEntry = ckRise && pwr_q == PS_ACTIVE && ckePrev_q && !ckeS;

	wire [2:0] clField = modeReg_q[`MR_CL_LSB +: 3];
	wire [2:0] latency = (clField < `MIN_READ_LATENCY) ? `MIN_READ_LATENCY : clField;
	wire [4:0] blBeats = burstBeats(modeReg_q[`MR_BL_LSB +: 3]);
	wire       interMode = modeReg_q[`MR_BT_BIT];

	// Read engine.
	reg  [2:0]       rdWait_q;
	reg              rdArmed_q;
	reg              rdRun_q;
	reg  [4:0]       rdLen_q;
	reg  [4:0]       rdDue_q;
	reg  [4:0]       rdIdx_q;
	reg  [COL_W-1:0] rdStart_q;
	reg  [1:0]       rdBank_q;
	reg              rdAp_q;
	reg              rdStatus_q;
	reg              rdStatusNext_q;
	reg              inflight_q;
	reg              inflightStatus_q;
	reg  [DATA_W-1:0] statusBeat_q;
	reg  [1:0]       bufCount_q;
	reg  [DATA_W-1:0] buf0_q;
	reg  [DATA_W-1:0] buf1_q;
	wire [2:0]       used = {1'b0, bufCount_q} + {2'b00, inflight_q};
	wire             room = used < 3'h2;
	wire             rdIssue = rdRun_q && rdIdx_q < rdDue_q && room;
	wire             rdLast = rdIssue && rdIdx_q == rdLen_q - 5'h01;
	wire [MEM_AW-1:0] rdAddrMem = {rdBank_q, beatCol(rdStart_q, rdIdx_q, rdLen_q, interMode)};
	wire [DATA_W-1:0] memRd;

	// Write engine.
	reg              wrPend_q;
	reg              wrRun_q;
	reg  [4:0]       wrLen_q;
	reg  [4:0]       wrIdx_q;
	reg  [COL_W-1:0] wrStart_q;
	reg  [1:0]       wrBank_q;
	reg              wrAp_q;
	wire             wrGo = wrPend_q && ckRise;
	wire             wrBeat = ckEdge && (wrRun_q || wrGo);
	wire [4:0]       wrIdxNow = wrGo ? 5'h00 : wrIdx_q;
	wire             wrLast = wrBeat && wrIdxNow == wrLen_q - 5'h01;
	wire [MEM_AW-1:0] wrAddrMem = {wrBank_q, beatCol(wrStart_q, wrIdxNow, wrLen_q, interMode)};

	sdram_word_store #(
		.DATA_W (DATA_W),
		.ADDR_W (MEM_AW),
		.MASK_W (MASK_W)
	) u_store (
		.clk    (clk),
		.wrEn   (wrBeat),
		.wrAddr (wrAddrMem),
		.wrData (wdS),
		.wrMask (dmS),
		.rdAddr (rdAddrMem),
		.rdData (memRd)
	);

	// Power state, mode registers, banks and refresh counter.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ckPrev_q      <= 1'b0;
			ckePrev_q     <= 1'b0;
			pwr_q         <= PS_ACTIVE;
			modeReg_q     <= `MR_RESET;
			extReg_q      <= `EMR_RESET;
			statusArmed_q <= 1'b0;
			openBanks     <= 4'h0;
			refreshRow    <= {ROW_W{1'b0}};
		end else begin
			ckPrev_q <= ckS;
			if (ckRise) begin
				ckePrev_q <= ckeS;
			end
			case (pwr_q)
				PS_ACTIVE: begin
					if (lowEntry && cmd == `CMD_REFRESH) begin
						pwr_q <= PS_SELF;
					end else if (lowEntry && cmd == `CMD_BURST_STOP) begin
						pwr_q    <= PS_DEEP;
						extReg_q <= `EMR_RESET;
					end
				end
				PS_SELF: begin
					if (ckRise && ckeS) begin
						pwr_q <= PS_ACTIVE;
					end
				end
				PS_DEEP: begin
					if (ckRise && ckeS) begin
						pwr_q <= PS_ACTIVE;
					end
				end
				default: pwr_q <= PS_ACTIVE;
			endcase
			if (cmdLive) begin
				case (cmd)
					`CMD_ACTIVE: openBanks[baS] <= 1'b1;
					`CMD_PRECHARGE: begin
						if (apBit) begin
							openBanks <= 4'h0;
						end else begin
							openBanks[baS] <= 1'b0;
						end
					end
					`CMD_REFRESH: refreshRow <= refreshRow + {{(ROW_W-1){1'b0}}, 1'b1};
					`CMD_LOAD_MODE: begin
						case (baS)
							`BA_SEL_MODE: modeReg_q <= addrS[6:0];
							`BA_SEL_EXT: extReg_q <= addrS[6:0] & `EMR_KEEP_MASK;
							`BA_SEL_STATUS: statusArmed_q <= 1'b1;
							default: statusArmed_q <= statusArmed_q;
						endcase
					end
					`CMD_READ: statusArmed_q <= 1'b0;
					default: statusArmed_q <= statusArmed_q;
				endcase
			end
			if (rdLast && rdAp_q && !rdStatus_q) begin
				openBanks[rdBank_q] <= 1'b0;
			end
			if (wrLast && wrAp_q) begin
				openBanks[wrBank_q] <= 1'b0;
			end
		end
	end

	// Read burst sequencing, latency wait and issue into the output buffer.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdWait_q         <= 3'h0;
			rdArmed_q        <= 1'b0;
			rdRun_q          <= 1'b0;
			rdLen_q          <= 5'h00;
			rdDue_q          <= 5'h00;
			rdIdx_q          <= 5'h00;
			rdStart_q        <= {COL_W{1'b0}};
			rdBank_q         <= 2'h0;
			rdAp_q           <= 1'b0;
			rdStatus_q       <= 1'b0;
			rdStatusNext_q   <= 1'b0;
			inflight_q       <= 1'b0;
			inflightStatus_q <= 1'b0;
			statusBeat_q     <= {DATA_W{1'b0}};
		end else begin
			inflight_q       <= rdIssue;
			inflightStatus_q <= rdStatus_q;
			statusBeat_q     <= (rdIdx_q == 5'h00) ? STATUS_WORD : {DATA_W{1'b0}};
			if (rdIssue) begin
				rdIdx_q <= rdIdx_q + 5'h01;
			end
			if (rdLast) begin
				rdRun_q <= 1'b0;
			end else if (rdRun_q && ckEdge && rdDue_q < rdLen_q) begin
				rdDue_q <= rdDue_q + 5'h01;
			end
			if (rdArmed_q && ckRise) begin
				if (rdWait_q == 3'h1) begin
					rdArmed_q  <= 1'b0;
					rdRun_q    <= 1'b1;
					rdDue_q    <= 5'h01;
					rdIdx_q    <= 5'h00;
					rdStatus_q <= rdStatusNext_q;
				end else begin
					rdWait_q <= rdWait_q - 3'h1;
				end
			end
			if (cmdLive && cmd == `CMD_READ) begin
				rdArmed_q      <= 1'b1;
				rdWait_q       <= latency - 3'h1;
				rdStatusNext_q <= statusArmed_q;
				rdLen_q        <= statusArmed_q ? `STATUS_BURST_BEATS : blBeats;
				rdStart_q      <= addrS[COL_W-1:0];
				rdBank_q       <= baS;
				rdAp_q         <= apBit;
			end else if (cmdLive && cmd == `CMD_BURST_STOP) begin
				rdArmed_q <= 1'b0;
				rdRun_q   <= 1'b0;
			end
		end
	end

	// Two-entry output buffer; a full buffer holds back the read issue.
	wire              push = inflight_q;
	wire              pop = rdValid && rdReady;
	wire [DATA_W-1:0] pushData = inflightStatus_q ? statusBeat_q : memRd;
	assign rdValid = bufCount_q != 2'h0;
	assign rdData  = buf0_q;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bufCount_q <= 2'h0;
			buf0_q     <= {DATA_W{1'b0}};
			buf1_q     <= {DATA_W{1'b0}};
		end else begin
			case ({push, pop})
				2'b10: begin
					if (bufCount_q == 2'h0) begin
						buf0_q <= pushData;
					end else begin
						buf1_q <= pushData;
					end
					bufCount_q <= bufCount_q + 2'h1;
				end
				2'b01: begin
					buf0_q     <= buf1_q;
					bufCount_q <= bufCount_q - 2'h1;
				end
				2'b11: begin
					if (bufCount_q == 2'h1) begin
						buf0_q <= pushData;
					end else begin
						buf0_q <= buf1_q;
						buf1_q <= pushData;
					end
				end
				default: bufCount_q <= bufCount_q;
			endcase
		end
	end

	// Write burst: first beat on the rising edge after the WRITE, then every edge.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_q  <= 1'b0;
			wrRun_q   <= 1'b0;
			wrLen_q   <= 5'h00;
			wrIdx_q   <= 5'h00;
			wrStart_q <= {COL_W{1'b0}};
			wrBank_q  <= 2'h0;
			wrAp_q    <= 1'b0;
		end else begin
			if (wrBeat) begin
				wrIdx_q <= wrIdxNow + 5'h01;
			end
			if (wrGo) begin
				wrPend_q <= 1'b0;
				wrRun_q  <= !wrLast;
			end else if (wrLast) begin
				wrRun_q <= 1'b0;
			end
			if (cmdLive && cmd == `CMD_WRITE) begin
				wrPend_q  <= 1'b1;
				wrLen_q   <= blBeats;
				wrStart_q <= addrS[COL_W-1:0];
				wrBank_q  <= baS;
				wrAp_q    <= apBit;
			end
		end
	end

	// Decoded mode fields and self-refresh coverage, all registered.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			casLatency        <= 3'h0;
			burstLenCode      <= 3'h0;
			burstInterleaved  <= 1'b0;
			pasrSelect        <= 3'h0;
			driveStrength     <= 2'h0;
			driveOhms         <= 7'h00;
			selfRefresh       <= 1'b0;
			deepPowerDown     <= 1'b0;
			refreshBankMask   <= 4'hF;
			refreshRowMsbZero <= 2'h0;
		end else begin
			casLatency       <= clField;
			burstLenCode     <= modeReg_q[`MR_BL_LSB +: 3];
			burstInterleaved <= interMode;
			pasrSelect       <= extReg_q[`EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB +: 3];
			driveStrength    <= extReg_q[`EMR_DS_LSB +: 2];
			case (extReg_q[`EMR_DS_LSB +: 2])
				2'h0:    driveOhms <= 7'h19;
				2'h1:    driveOhms <= 7'h24;
				2'h2:    driveOhms <= 7'h37;
				default: driveOhms <= 7'h50;
			endcase
			selfRefresh   <= pwr_q == PS_SELF;
			deepPowerDown <= pwr_q == PS_DEEP;
			if (pwr_q == PS_SELF) begin
				case (extReg_q[`EMR_PARTIAL_ARRAY_REFRESH_SELECT_LSB +: 3])
					`PARTIAL_ARRAY_REFRESH_SELECT_HALF:      {refreshBankMask, refreshRowMsbZero} <= {4'h3, 2'h0};
					`PARTIAL_ARRAY_REFRESH_SELECT_QUARTER:   {refreshBankMask, refreshRowMsbZero} <= {4'h1, 2'h0};
					`PARTIAL_ARRAY_REFRESH_SELECT_EIGHTH:    {refreshBankMask, refreshRowMsbZero} <= {4'h1, 2'h1};
					`PARTIAL_ARRAY_REFRESH_SELECT_SIXTEENTH: {refreshBankMask, refreshRowMsbZero} <= {4'h1, 2'h3};
					default:         {refreshBankMask, refreshRowMsbZero} <= {4'hF, 2'h0};
				endcase
			end else begin
				refreshBankMask   <= 4'hF;
				refreshRowMsbZero <= 2'h0;
			end
		end
	end
endmodule // sdram_command_mode_logic
`default_nettype wire

// ### sdram_cmd_checker_sva.sv
// Checker for power state, field outputs, refresh counter and read stream hold.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_checker #(
	parameter DATA_W = 16,
	parameter ROW_W  = 13
) (
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              linkClk,
	input wire logic [DATA_W-1:0] rdData,
	input wire logic              rdValid,
	input wire logic              rdReady,
	input wire logic [2:0]        casLatency,
	input wire logic [2:0]        pasrSelect,
	input wire logic [1:0]        driveStrength,
	input wire logic [6:0]        driveOhms,
	input wire logic              selfRefresh,
	input wire logic              deepPowerDown,
	input wire logic [3:0]        refreshBankMask,
	input wire logic [1:0]        refreshRowMsbZero,
	input wire logic [ROW_W-1:0]  refreshRow
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [1:0] up_q;
	logic [3:0] since_q;
	logic       linkPrev_q;
	logic [6:0] ohms;
	logic [3:0] keepMask;
	logic [1:0] keepRows;
	// Cycles since the last link clock rise, so field updates can be tied to a command edge.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 2'h0;
			since_q <= 4'hF;
			linkPrev_q <= 1'b0;
		end else begin
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
			linkPrev_q <= linkClk;
			since_q <= (linkClk && !linkPrev_q) ? 4'h0 : ((&since_q) ? since_q : since_q + 4'h1);
		end
	end
	always @* begin
		ohms = (driveStrength == 2'h0) ? 7'h19 : (driveStrength == 2'h1) ? 7'h24 :
			(driveStrength == 2'h2) ? 7'h37 : 7'h50;
		keepMask = (pasrSelect == 3'h1) ? 4'h3 : (pasrSelect == 3'h2 || pasrSelect == 3'h5
			|| pasrSelect == 3'h6) ? 4'h1 : 4'hF;
		keepRows = (pasrSelect == 3'h6) ? 2'h3 : (pasrSelect == 3'h5) ? 2'h1 : 2'h0;
	end
	ohms_map_a: assert property (up_q == 2'h3 && $stable(driveStrength) &&
		$past(driveStrength, 2) == driveStrength |-> driveOhms == ohms)
		else $error("drive impedance does not match drive code");
	keep_mask_a: assert property (selfRefresh && $past(selfRefresh, 2) |->
		refreshBankMask == keepMask && refreshRowMsbZero == keepRows)
		else $error("kept refresh region does not match select code");
	idle_mask_a: assert property (up_q == 2'h3 && !selfRefresh && !$past(selfRefresh, 2) |->
		refreshBankMask == 4'hF && refreshRowMsbZero == 2'h0)
		else $error("refresh region narrowed outside self refresh");
	power_excl_a: assert property (!(selfRefresh && deepPowerDown))
		else $error("self refresh and deep power-down at once");
	read_hold_a: assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
		else $error("read word dropped or changed while stalled");
	dpd_clear_a: assert property ($rose(deepPowerDown) |-> ##[0:2]
		(pasrSelect == 3'h0 && driveStrength == 2'h0))
		else $error("extended settings kept through deep power-down");
	field_time_a: assert property (up_q == 2'h3 && ($changed(casLatency) ||
		$changed(driveStrength) || $changed(selfRefresh)) |-> since_q inside {[4'h2:4'hC]})
		else $error("setting changed away from a command edge");
	row_step_a: assert property (up_q == 2'h3 && $changed(refreshRow) |->
		refreshRow == $past(refreshRow) + 1'b1 && !$past(selfRefresh))
		else $error("refresh row counter stepped wrongly");
	sr_cov: cover property (selfRefresh && refreshBankMask == 4'h1);
	dpd_cov: cover property (deepPowerDown);
	stall_cov: cover property (rdValid && !rdReady);
endmodule // sdram_cmd_checker

bind sdram_command_mode_logic sdram_cmd_checker #(.DATA_W(DATA_W), .ROW_W(ROW_W)) sdram_cmd_checker_i (
	.clk(clk), .rstn(rstn), .linkClk(linkClk), .rdData(rdData), .rdValid(rdValid),
	.rdReady(rdReady), .casLatency(casLatency), .pasrSelect(pasrSelect),
	.driveStrength(driveStrength), .driveOhms(driveOhms), .selfRefresh(selfRefresh),
	.deepPowerDown(deepPowerDown), .refreshBankMask(refreshBankMask),
	.refreshRowMsbZero(refreshRowMsbZero), .refreshRow(refreshRow)
);
`default_nettype wire

// ### mem_ctl_model.sv
// Memory controller model: free-running link clock, one command per link rise, write beats.
// Assumes the caller steps it from clk edges; all pins change on clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module mem_ctl_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	output logic             linkClk,
	output logic             cke,
	output logic             csN,
	output logic             rasN,
	output logic             casN,
	output logic             weN,
	output logic [1:0]       ba,
	output logic [13:0]      addr,
	output logic [15:0]      wrData,
	output logic [1:0]       dm
);
	logic [4:0] ph_q;
	initial begin
		ph_q = 5'h00;
		linkClk = 1'b0;
		cke = 1'b1;
		{csN, rasN, casN, weN} = 4'hF;
		ba = 2'h0;
		addr = 14'h0000;
		wrData = 16'h0000;
		dm = 2'h0;
	end
	// The link clock is one twentieth of clk and stays low while reset is held.
	always @(posedge clk) begin
		ph_q <= (!rstn || ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
		linkClk <= rstn && ph_q >= 5'h09 && ph_q <= 5'h12;
	end
	task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
			input logic k);
		while (ph_q != 5'h04) @(posedge clk);
		{csN, rasN, casN, weN} <= c;
		ba <= b;
		addr <= a;
		cke <= k;
		repeat (16) @(posedge clk);
		{csN, rasN, casN, weN} <= 4'h7;
		ba <= ~b;
		addr <= ~a;
	endtask
	task automatic beats(input logic [15:0] d0, input logic [1:0] m);
		int i;
		repeat (4) @(posedge clk);
		for (i = 0; i < 4; i++) begin
			wrData <= d0 ^ 16'(i);
			dm <= m;
			repeat (10) @(posedge clk);
		end
		wrData <= ~d0;
		dm <= ~m;
	endtask
endmodule // mem_ctl_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the command decoder and mode-register logic.
// Assumes the controller model drives all pins and the bench drives only clk, rstn and rdReady.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [15:0] SW = 16'h5A3C;
	logic clk, rstn, rdReady, linkClk, cke, csN, rasN, casN, weN, rdValid;
	logic [1:0] ba, dm, driveStrength, refreshRowMsbZero;
	logic [13:0] addr;
	logic [15:0] wrData, rdData;
	logic [2:0] casLatency, burstLenCode, pasrSelect;
	logic burstInterleaved, selfRefresh, deepPowerDown;
	logic [6:0] driveOhms;
	logic [3:0] refreshBankMask, openBanks;
	logic [12:0] refreshRow, row0;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;
	mem_ctl_model mem_ctl_model_i (.clk(clk), .rstn(rstn), .linkClk(linkClk), .cke(cke),
		.csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr),
		.wrData(wrData), .dm(dm));
	sdram_command_mode_logic #(.STATUS_WORD(SW)) sdram_command_mode_logic_i (.clk(clk),
		.rstn(rstn), .linkClk(linkClk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .ba(ba), .addr(addr), .wrData(wrData), .dm(dm), .rdData(rdData),
		.rdValid(rdValid), .rdReady(rdReady), .casLatency(casLatency),
		.burstLenCode(burstLenCode), .burstInterleaved(burstInterleaved),
		.pasrSelect(pasrSelect), .driveStrength(driveStrength), .driveOhms(driveOhms),
		.selfRefresh(selfRefresh), .deepPowerDown(deepPowerDown),
		.refreshBankMask(refreshBankMask), .refreshRowMsbZero(refreshRowMsbZero),
		.openBanks(openBanks), .refreshRow(refreshRow));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			$display("[ERR] %0t run did not finish", $time);
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// Issue one command and let the synchronised result settle before checking.
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a,
			input logic k);
		mem_ctl_model_i.send(c, b, a, k);
		repeat (4) @(posedge clk);
	endtask
	// Read n words against four packed expected words; hold keeps the receiver stalled for that many cycles.
	task automatic rd(input logic [1:0] b, input logic [13:0] a, input logic [63:0] e,
			input int n, input int lo, input int hi, input int hold);
		int t, got, first;
		got = 0;
		first = -1;
		mem_ctl_model_i.send(4'h5, b, a, 1'b1);
		rdReady <= (hold == 0);
		for (t = 1; t <= 100 + hold; t++) begin
			@(posedge clk);
			if (rdValid === 1'b1 && rdReady === 1'b1) begin
				if (got < n) chk(rdData, e[63 - 16 * got -: 16]);
				if (first < 0) first = t;
				got++;
			end
			if (t == hold) rdReady <= 1'b1;
		end
		chk(16'(got), 16'(n));
		if (hold == 0) chk(16'(first >= lo && first <= hi), 16'h0001);
	endtask
	// Close all banks, load the mode register, then reopen bank 1 for the next read.
	task automatic set_mode(input logic [13:0] a);
		cmd(4'h2, 2'h0, 14'h0400, 1'b1);
		cmd(4'h0, 2'h0, a, 1'b1);
		cmd(4'h3, 2'h1, 14'h0123, 1'b1);
	endtask
	task automatic t_reset();
		chk(16'(casLatency), 16'h0003);
		chk(16'(burstLenCode), 16'h0002);
		chk(16'(driveOhms), 16'h0019);
		chk(16'(refreshBankMask), 16'h000F);
	endtask
	task automatic t_ext();
		logic [6:0] ohms [4];
		int d;
		ohms = '{7'h19, 7'h24, 7'h37, 7'h50};
		for (d = 0; d < 4; d++) begin
			cmd(4'h0, 2'h2, 14'(d * 32 + 24), 1'b1);
			chk(16'(driveStrength), 16'(d));
			chk(16'(driveOhms), 16'(ohms[d]));
		end
	endtask
	task automatic t_ignore();
		cmd(4'h0, 2'h3, 14'h0011, 1'b1);
		chk(16'(driveStrength), 16'h0003);
		cmd(4'h8, 2'h0, 14'h0011, 1'b1);
		chk(16'(casLatency), 16'h0003);
	endtask
	task automatic t_rw();
		cmd(4'h0, 2'h0, 14'h0022, 1'b1);
		chk(16'(casLatency), 16'h0002);
		cmd(4'h3, 2'h1, 14'h0123, 1'b1);
		chk(16'(openBanks), 16'h0002);
		mem_ctl_model_i.send(4'h4, 2'h1, 14'h0004, 1'b1);
		mem_ctl_model_i.beats(16'hA1B0, 2'h0);
		mem_ctl_model_i.send(4'h4, 2'h1, 14'h0004, 1'b1);
		mem_ctl_model_i.beats(16'h5C20, 2'h1);
		rd(2'h1, 14'h0005, 64'h5CB1_5CB2_5CB3_5CB0, 4, 10, 22, 0);
		set_mode(14'h0032);
		rd(2'h1, 14'h0005, 64'h5CB1_5CB2_5CB3_5CB0, 4, 30, 42, 0);
		set_mode(14'h003A);
		chk(16'(burstInterleaved), 16'h0001);
		rd(2'h1, 14'h0005, 64'h5CB1_5CB0_5CB3_5CB2, 4, 30, 42, 60);
		set_mode(14'h0039);
		chk(16'(burstLenCode), 16'h0001);
		rd(2'h1, 14'h0006, 64'h5CB2_5CB3_0000_0000, 2, 30, 42, 0);
		set_mode(14'h003A);
		rd(2'h1, 14'h0405, 64'h5CB1_5CB0_5CB3_5CB2, 4, 30, 42, 0);
		chk(16'(openBanks), 16'h0000);
	endtask
	task automatic t_pre();
		cmd(4'h3, 2'h0, 14'h0001, 1'b1);
		cmd(4'h3, 2'h2, 14'h0001, 1'b1);
		cmd(4'h3, 2'h3, 14'h0001, 1'b1);
		chk(16'(openBanks), 16'h000D);
		cmd(4'h2, 2'h2, 14'h0000, 1'b1);
		chk(16'(openBanks), 16'h0009);
		cmd(4'h2, 2'h2, 14'h0400, 1'b1);
		chk(16'(openBanks), 16'h0000);
	endtask
	// A terminate before the first beat must leave the stalled buffer empty.
	task automatic t_stop();
		cmd(4'h3, 2'h2, 14'h0001, 1'b1);
		rdReady <= 1'b0;
		mem_ctl_model_i.send(4'h5, 2'h2, 14'h0000, 1'b1);
		cmd(4'h6, 2'h0, 14'h0000, 1'b1);
		repeat (60) @(posedge clk);
		chk(16'(rdValid), 16'h0000);
		rdReady <= 1'b1;
		mem_ctl_model_i.send(4'h4, 2'h2, 14'h0400, 1'b1);
		mem_ctl_model_i.beats(16'h1234, 2'h0);
		repeat (4) @(posedge clk);
		chk(16'(openBanks), 16'h0000);
	endtask
	task automatic t_status();
		cmd(4'h0, 2'h1, 14'h0000, 1'b1);
		cmd(4'h7, 2'h0, 14'h0000, 1'b1);
		rd(2'h0, 14'h0000, {SW, 48'h0}, 2, 30, 42, 0);
	endtask
	task automatic t_refresh();
		row0 = refreshRow;
		cmd(4'h1, 2'h3, 14'h3FFF, 1'b1);
		chk(16'(refreshRow), 16'(row0 + 13'h0001));
	endtask
	task automatic t_selfref();
		logic [2:0] codes [5];
		logic [3:0] masks [5];
		logic [1:0] rows [5];
		int i;
		codes = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
		masks = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
		rows = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
		for (i = 0; i < 5; i++) begin
			cmd(4'h0, 2'h2, {9'h001, 2'h0, codes[i]}, 1'b1);
			chk(16'(pasrSelect), 16'(codes[i]));
			chk(16'(refreshBankMask), 16'h000F);
			cmd(4'h1, 2'h0, 14'h3FFF, 1'b0);
			chk(16'(selfRefresh), 16'h0001);
			chk(16'({refreshBankMask, refreshRowMsbZero}), 16'({masks[i], rows[i]}));
			cmd(4'h7, 2'h0, 14'h0000, 1'b1);
			chk(16'(selfRefresh), 16'h0000);
		end
	endtask
	task automatic t_dpd();
		cmd(4'h0, 2'h2, 14'h0065, 1'b1);
		chk(16'(driveOhms), 16'h0050);
		cmd(4'h6, 2'h0, 14'h0000, 1'b0);
		chk(16'(deepPowerDown), 16'h0001);
		cmd(4'h7, 2'h0, 14'h0000, 1'b1);
		chk(16'({pasrSelect, driveOhms}), 16'h0019);
		chk(16'(casLatency), 16'h0003);
	endtask
	initial begin
		rstn = 1'b0;
		rdReady = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (8) @(posedge clk);
		t_reset();
		t_ext();
		t_ignore();
		t_rw();
		t_pre();
		t_stop();
		t_status();
		t_refresh();
		t_selfref();
		t_dpd();
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
